// ==== design/usbdr_cfg.svh ====
`ifndef USBDR_CFG_SVH
`define USBDR_CFG_SVH

`define USBDR_NUM_CH        16
`define USBDR_NUM_EP        16
`define USBDR_NUM_FIFO      17
`define USBDR_RX_FIFO       5'h10
`define USBDR_HOST_PER_FIFO 5'h00
`define USBDR_HOST_NP_FIFO  5'h01
`define USBDR_MAX_PER_IN    5'h07
`define USBDR_RAM_WORDS     1024
`define USBDR_RAM_AW        10
`define USBDR_FIFO_SIZE_RST 10'h030
`define USBDR_SPD_HS        2'h0
`define USBDR_SPD_FS        2'h1
`define USBDR_SPD_LS        2'h2
`define USBDR_GRP_GLOBAL    4'h0
`define USBDR_GRP_HOST      4'h1
`define USBDR_GRP_DEVICE    4'h2
`define USBDR_GRP_POWER     4'h3
`define USBDR_GRP_RAM       4'h4
`define USBDR_GRP_SHARED    4'h5
`define USBDR_REG_RST       32'h0000_0000
`define USBDR_PHY_MIN_EDGES 4'hC
`define USBDR_ULPI_IDLE     8'h00

`endif

// ==== design/usbdr_pkg.sv ====
package usbdr_pkg;

  typedef enum logic [2:0] {
    LINK_IDLE = 3'b001,
    LINK_SEND = 3'b010,
    LINK_STOP = 3'b100
  } usbdr_link_type;

  typedef logic [9:0] usbdr_words_type;

endpackage

// ==== design/usbdr_core.sv ====
// Functional notes
// - Host runs HS, FS or LS; device runs HS or FS only.
// - Host mode schedules up to sixteen programmable channels.
// - Device mode offers sixteen bidirectional endpoints including endpoint zero.
// - At most seven device IN endpoints may be periodic.
// - Hardware schedules transactions and issues PING automatically after NAK at high speed.
// - A setting selects OTG revision 1.3 or 2.0 behaviour.
// - Device mode gives each IN endpoint its own transmit FIFO.
// - FIFO sizes are programmable per FIFO and changeable during transfers.
// - Suspend or session off allows PHY, system and RAM clocks gated.
// - DMA moves packet data between memory and protocol engine.
// - Slave accesses are full 32-bit; all groups readable and writable.
// - Slave port also reaches packet RAM for test.
// - Wrong-mode register access raises a mode mismatch interrupt.
// - Writes to unimplemented addresses ignored; reads return zero.
// - Shared register locations are interpreted by current mode.
// - FIFO thresholds trigger DMA requests, not interrupts, in both modes.
// - DMA scheduler arbitrates among endpoints, moving each packet.
// - Host uses one periodic and one nonperiodic transmit FIFO.
// - One receive FIFO serves all packets in both modes.
// - One interrupt output toward the processor.
// - PHY link is 8-bit SDR sampled on rising PHY clock.
`timescale 1ns/1ps
`default_nettype none
`include "usbdr_cfg.svh"

module usbdr_core (
  input  wire logic        REF_CLK,
  input  wire logic        RESET_N,
  input  wire logic        CE,
  input  wire logic        HOST_MODE,
  input  wire logic [1:0]  SPEED_REQ,
  output logic      [1:0]  SPEED_OUT,
  input  wire logic        OTG_REV_SEL,
  output logic             OTG_REV,
  input  wire logic        SUSPEND,
  input  wire logic        SESSION_OFF,
  output logic             GATE_PHY_CLK,
  output logic             GATE_SYS_CLK,
  output logic             GATE_RAM_CLK,
  input  wire logic [15:0] ACTIVE_MASK,
  input  wire logic [15:0] EP_PERIODIC,
  output logic      [15:0] PERIODIC_EP,
  output logic             PERIODIC_OVER,
  input  wire logic        SIZE_WE,
  input  wire logic [4:0]  SIZE_IDX,
  input  wire logic [9:0]  SIZE_WORDS,
  input  wire logic [9:0]  THRESHOLD,
  input  wire logic        PKT_PUSH,
  input  wire logic        PKT_POP,
  input  wire logic        PKT_RX,
  input  wire logic        PKT_PERIODIC,
  input  wire logic [3:0]  PKT_EP,
  input  wire logic [9:0]  PKT_LEN,
  output logic             PKT_REFUSED,
  output logic             DMA_REQ,
  output logic      [4:0]  DMA_FIFO,
  input  wire logic        DMA_ACK,
  output logic             SCHED_VALID,
  output logic      [3:0]  SCHED_IDX,
  output logic             XFER_PING,
  input  wire logic        XFER_ACK,
  input  wire logic        XFER_NAK,
  input  wire logic        ACC_VALID,
  input  wire logic        ACC_WRITE,
  input  wire logic [15:0] ACC_ADDR,
  input  wire logic [31:0] ACC_WDATA,
  output logic      [31:0] ACC_RDATA,
  output logic             IRQ,
  input  wire logic        IRQ_CLR,
  input  wire logic        ULPI_CLK,
  input  wire logic        ULPI_DIR,
  input  wire logic        ULPI_NXT,
  input  wire logic [7:0]  ULPI_DATA_I,
  output logic      [7:0]  ULPI_DATA_O,
  output logic             ULPI_DATA_OE,
  output logic             ULPI_STP,
  input  wire logic        TX_VALID,
  input  wire logic [7:0]  TX_DATA,
  input  wire logic        TX_LAST,
  output logic             TX_READY,
  output logic             RX_VALID,
  output logic      [7:0]  RX_DATA
);

  localparam int NF = `USBDR_NUM_FIFO;

  // Round-robin pick: first set bit after the last grant
  function automatic logic [4:0] rr_pick(input logic [16:0] req, input logic [4:0] last);
    logic [4:0] idx;
    logic       hit;
    int         k;
    idx = last;
    hit = 1'b0;
    for (k = 1; k <= NF; k++) begin
      if (!hit && req[(int'(last) + k) % NF]) begin
        idx = 5'((int'(last) + k) % NF);
        hit = 1'b1;
      end
    end
    return idx;
  endfunction

  // Maps a packet to its FIFO; host shares two transmit FIFOs
  function automatic logic [4:0] fifo_of(input logic host, input logic rx,
                                         input logic per, input logic [3:0] ep);
    if (rx)
      return `USBDR_RX_FIFO;
    else if (host)
      return per ? `USBDR_HOST_PER_FIFO : `USBDR_HOST_NP_FIFO;
    else
      return {1'b0, ep};
  endfunction

  // Speed, revision and clock gating
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      SPEED_OUT    <= `USBDR_SPD_FS;
      OTG_REV      <= 1'b0;
      GATE_PHY_CLK <= 1'b0;
      GATE_SYS_CLK <= 1'b0;
      GATE_RAM_CLK <= 1'b0;
    end else if (CE) begin
      if (!HOST_MODE && SPEED_REQ == `USBDR_SPD_LS)
        SPEED_OUT <= `USBDR_SPD_FS;
      else
        SPEED_OUT <= SPEED_REQ;
      OTG_REV      <= OTG_REV_SEL;
      GATE_PHY_CLK <= SUSPEND | SESSION_OFF;
      GATE_SYS_CLK <= SUSPEND | SESSION_OFF;
      GATE_RAM_CLK <= SUSPEND | SESSION_OFF;
    end
  end

  // Periodic IN limit: first seven requested endpoints win
  logic [15:0] per_nxt;
  logic        per_over_nxt;
  always_comb begin
    logic [4:0] cnt;
    cnt = 5'h00;
    per_nxt = 16'h0000;
    per_over_nxt = 1'b0;
    for (int e = 0; e < `USBDR_NUM_EP; e++) begin
      if (!HOST_MODE && EP_PERIODIC[e] && ACTIVE_MASK[e]) begin
        if (cnt < `USBDR_MAX_PER_IN) begin
          per_nxt[e] = 1'b1;
          cnt = cnt + 5'h01;
        end else begin
          per_over_nxt = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PERIODIC_EP   <= 16'h0000;
      PERIODIC_OVER <= 1'b0;
    end else if (CE) begin
      PERIODIC_EP   <= per_nxt;
      PERIODIC_OVER <= per_over_nxt;
    end
  end

  // FIFO sizes and fill levels; sizes writable at any time
  usbdr_pkg::usbdr_words_type size_r [NF];
  usbdr_pkg::usbdr_words_type fill_r [NF];
  logic [4:0]  pkt_fifo;
  logic [10:0] pkt_sum;
  logic [NF-1:0] dma_want;
  assign pkt_fifo = fifo_of(HOST_MODE, PKT_RX, PKT_PERIODIC, PKT_EP);
  assign pkt_sum  = {1'b0, fill_r[pkt_fifo]} + {1'b0, PKT_LEN};

  genvar g;
  generate
    for (g = 0; g < NF; g++) begin : g_fifo
      always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
          size_r[g] <= `USBDR_FIFO_SIZE_RST;
          fill_r[g] <= 10'h000;
        end else if (CE) begin
          if (SIZE_WE && SIZE_IDX == 5'(g))
            size_r[g] <= SIZE_WORDS;
          if (PKT_PUSH && pkt_fifo == 5'(g) && pkt_sum <= {1'b0, size_r[g]})
            fill_r[g] <= pkt_sum[9:0];
          else if (!PKT_PUSH && PKT_POP && pkt_fifo == 5'(g))
            fill_r[g] <= (fill_r[g] > PKT_LEN) ? fill_r[g] - PKT_LEN : 10'h000;
        end
      end
      // Transmit FIFOs ask to be filled, the receive FIFO to be drained
      if (g == NF - 1) begin : g_rx
        assign dma_want[g] = fill_r[g] >= THRESHOLD;
      end else begin : g_tx
        assign dma_want[g] = fill_r[g] < THRESHOLD &&
          (HOST_MODE ? (g < 2) : ACTIVE_MASK[g]);
      end
    end
  endgenerate

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N)
      PKT_REFUSED <= 1'b0;
    else if (CE)
      PKT_REFUSED <= PKT_PUSH && pkt_sum > {1'b0, size_r[pkt_fifo]};
  end

  // DMA scheduler: request held until acknowledged, then rotate
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      DMA_REQ  <= 1'b0;
      DMA_FIFO <= `USBDR_RX_FIFO;
    end else if (CE) begin
      if (DMA_REQ && DMA_ACK)
        DMA_REQ <= 1'b0;
      else if (!DMA_REQ && |dma_want) begin
        DMA_REQ  <= 1'b1;
        DMA_FIFO <= rr_pick(dma_want, DMA_FIFO);
      end
    end
  end

  // Transaction scheduler over channels or endpoints with ping tracking
  logic [15:0] ping_r;
  logic [4:0]  sched_pick;
  assign sched_pick = rr_pick({1'b0, ACTIVE_MASK}, {1'b0, SCHED_IDX});
  assign XFER_PING  = SCHED_VALID && ping_r[SCHED_IDX] && SPEED_OUT == `USBDR_SPD_HS;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      SCHED_VALID <= 1'b0;
      SCHED_IDX   <= 4'hF;
      ping_r      <= 16'h0000;
    end else if (CE) begin
      if (SCHED_VALID && XFER_NAK)
        ping_r[SCHED_IDX] <= 1'b1;
      else if (SCHED_VALID && XFER_ACK)
        ping_r[SCHED_IDX] <= 1'b0;
      if (!SCHED_VALID || XFER_ACK || XFER_NAK) begin
        SCHED_VALID <= |ACTIVE_MASK;
        SCHED_IDX   <= sched_pick[3:0];
      end
    end
  end

  // Slave access port: register groups and packet RAM test path
  logic [31:0] ram [`USBDR_RAM_WORDS];
  logic [31:0] grp_r [4];
  logic [31:0] shared_r [2];
  logic [3:0]  acc_grp;
  logic        acc_impl;
  logic        mismatch;
  assign acc_grp  = ACC_ADDR[15:12];
  assign acc_impl = acc_grp == `USBDR_GRP_RAM || acc_grp == `USBDR_GRP_SHARED ||
                    (acc_grp < `USBDR_GRP_RAM && ACC_ADDR[11:0] == 12'h000);
  assign mismatch = ACC_VALID && ((HOST_MODE && acc_grp == `USBDR_GRP_DEVICE) ||
                    (!HOST_MODE && acc_grp == `USBDR_GRP_HOST));

  always_ff @(posedge REF_CLK) begin
    if (CE && ACC_VALID && ACC_WRITE && acc_grp == `USBDR_GRP_RAM)
      ram[ACC_ADDR[`USBDR_RAM_AW+1:2]] <= ACC_WDATA;
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < 4; i++)
        grp_r[i] <= `USBDR_REG_RST;
      shared_r[0] <= `USBDR_REG_RST;
      shared_r[1] <= `USBDR_REG_RST;
    end else if (CE && ACC_VALID && ACC_WRITE && acc_impl) begin
      if (acc_grp == `USBDR_GRP_SHARED)
        shared_r[HOST_MODE] <= ACC_WDATA;
      else if (acc_grp < `USBDR_GRP_RAM)
        grp_r[acc_grp[1:0]] <= ACC_WDATA;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N)
      ACC_RDATA <= 32'h0000_0000;
    else if (CE && ACC_VALID && !ACC_WRITE) begin
      if (!acc_impl)
        ACC_RDATA <= 32'h0000_0000;
      else if (acc_grp == `USBDR_GRP_RAM)
        ACC_RDATA <= ram[ACC_ADDR[`USBDR_RAM_AW+1:2]];
      else if (acc_grp == `USBDR_GRP_SHARED)
        ACC_RDATA <= shared_r[HOST_MODE];
      else
        ACC_RDATA <= grp_r[acc_grp[1:0]];
    end
  end

  // Sticky interrupt; a new mismatch beats a simultaneous clear
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N)
      IRQ <= 1'b0;
    else if (CE) begin
      if (mismatch || PKT_REFUSED)
        IRQ <= 1'b1;
      else if (IRQ_CLR)
        IRQ <= 1'b0;
    end
  end

  // PHY link: every pin passes two flops before use
  logic [10:0] lk_s1;
  logic [10:0] lk_s2;
  logic        lclk_d;
  logic        ledge;
  logic [3:0]  ledge_cnt;
  logic        link_ok;
  logic        dir_s;
  logic        nxt_s;
  logic        last_r;
  usbdr_pkg::usbdr_link_type link_st;

  assign dir_s   = lk_s2[9];
  assign nxt_s   = lk_s2[8];
  assign ledge   = lk_s2[10] && !lclk_d;
  assign link_ok = ledge_cnt == `USBDR_PHY_MIN_EDGES;
  assign ULPI_DATA_OE = !dir_s;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      lk_s1     <= 11'h000;
      lk_s2     <= 11'h000;
      lclk_d    <= 1'b0;
      ledge_cnt <= 4'h0;
    end else if (CE) begin
      lk_s1  <= {ULPI_CLK, ULPI_DIR, ULPI_NXT, ULPI_DATA_I};
      lk_s2  <= lk_s1;
      lclk_d <= lk_s2[10];
      if (ledge && !link_ok)
        ledge_cnt <= ledge_cnt + 4'h1;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RX_VALID <= 1'b0;
      RX_DATA  <= 8'h00;
    end else if (CE) begin
      RX_VALID <= ledge && dir_s && nxt_s;
      if (ledge && dir_s && nxt_s)
        RX_DATA <= lk_s2[7:0];
    end
  end

  // Transmit walk: drive byte, advance on NXT, end with one STP cycle
  always_comb begin
    TX_READY = 1'b0;
    if (ledge && !dir_s && link_ok && TX_VALID) begin
      if (link_st == usbdr_pkg::LINK_IDLE)
        TX_READY = 1'b1;
      else if (link_st == usbdr_pkg::LINK_SEND && nxt_s && !last_r)
        TX_READY = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      link_st     <= usbdr_pkg::LINK_IDLE;
      ULPI_DATA_O <= `USBDR_ULPI_IDLE;
      ULPI_STP    <= 1'b1;
      last_r      <= 1'b0;
    end else if (CE) begin
      if (!link_ok)
        ULPI_STP <= 1'b1;
      else if (ledge && !dir_s) begin
        case (link_st)
          usbdr_pkg::LINK_IDLE: begin
            ULPI_STP <= 1'b0;
            if (TX_VALID) begin
              ULPI_DATA_O <= TX_DATA;
              last_r      <= TX_LAST;
              link_st     <= usbdr_pkg::LINK_SEND;
            end
          end
          usbdr_pkg::LINK_SEND: begin
            if (nxt_s && last_r) begin
              ULPI_DATA_O <= `USBDR_ULPI_IDLE;
              ULPI_STP    <= 1'b1;
              link_st     <= usbdr_pkg::LINK_STOP;
            end else if (nxt_s && TX_VALID) begin
              ULPI_DATA_O <= TX_DATA;
              last_r      <= TX_LAST;
            end
          end
          usbdr_pkg::LINK_STOP: begin
            ULPI_STP <= 1'b0;
            link_st  <= usbdr_pkg::LINK_IDLE;
          end
          default: link_st <= usbdr_pkg::LINK_IDLE;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ==== test/usbdr_core_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "usbdr_cfg.svh"
module usbdr_core_sva (
  input wire logic        REF_CLK,
  input wire logic        RESET_N,
  input wire logic        CE,
  input wire logic        HOST_MODE,
  input wire logic [1:0]  SPEED_REQ,
  input wire logic [1:0]  SPEED_OUT,
  input wire logic        OTG_REV_SEL,
  input wire logic        OTG_REV,
  input wire logic        SUSPEND,
  input wire logic        SESSION_OFF,
  input wire logic        GATE_PHY_CLK,
  input wire logic        GATE_SYS_CLK,
  input wire logic        GATE_RAM_CLK,
  input wire logic [15:0] PERIODIC_EP,
  input wire logic        PKT_REFUSED,
  input wire logic        DMA_REQ,
  input wire logic [4:0]  DMA_FIFO,
  input wire logic        DMA_ACK,
  input wire logic        ACC_VALID,
  input wire logic        ACC_WRITE,
  input wire logic [15:0] ACC_ADDR,
  input wire logic [31:0] ACC_RDATA,
  input wire logic        IRQ,
  input wire logic        ULPI_STP
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RESET_N);
  sequence s_wrong_acc;
    CE && ACC_VALID && ACC_ADDR[15:12] == (HOST_MODE ? `USBDR_GRP_DEVICE : `USBDR_GRP_HOST);
  endsequence
  sequence s_dma_taken;
    CE && DMA_REQ && DMA_ACK;
  endsequence
  property p_speed;
    CE |=> SPEED_OUT == (($past(HOST_MODE) || $past(SPEED_REQ) != `USBDR_SPD_LS) ?
                         $past(SPEED_REQ) : `USBDR_SPD_FS);
  endproperty
  property p_otg;
    CE |=> OTG_REV == $past(OTG_REV_SEL);
  endproperty
  property p_gate;
    CE |=> {GATE_PHY_CLK, GATE_SYS_CLK, GATE_RAM_CLK} == {3{$past(SUSPEND || SESSION_OFF)}};
  endproperty
  property p_per;
    CE |=> $countones(PERIODIC_EP) <= 7 && (!$past(HOST_MODE) || PERIODIC_EP == 16'h0000);
  endproperty
  property p_refuse_irq;
    CE && PKT_REFUSED |=> IRQ;
  endproperty
  property p_mismatch;
    s_wrong_acc |=> IRQ;
  endproperty
  property p_unimpl;
    CE && ACC_VALID && !ACC_WRITE && ACC_ADDR[15:12] > `USBDR_GRP_SHARED
      |=> ACC_RDATA == `USBDR_REG_RST;
  endproperty
  property p_dma_hold;
    DMA_REQ && !(CE && DMA_ACK) |=> DMA_REQ && $stable(DMA_FIFO);
  endproperty
  property p_dma_drop;
    s_dma_taken |=> !DMA_REQ;
  endproperty
  // Twelve link edges take far longer than eight system cycles
  property p_stp;
    $rose(RESET_N) |-> ULPI_STP [*8];
  endproperty
  a_speed: assert property (p_speed) else $error("speed wrong");
  a_otg: assert property (p_otg) else $error("revision wrong");
  a_gate: assert property (p_gate) else $error("gate permit wrong");
  a_per: assert property (p_per) else $error("periodic set wrong");
  a_refuse_irq: assert property (p_refuse_irq) else $error("no irq on refusal");
  a_mismatch: assert property (p_mismatch) else $error("no mismatch irq");
  a_unimpl: assert property (p_unimpl) else $error("unmapped read not zero");
  a_dma_hold: assert property (p_dma_hold) else $error("dma request dropped");
  a_dma_drop: assert property (p_dma_drop) else $error("dma request held");
  a_stp: assert property (p_stp) else $error("stop released early");
endmodule
bind usbdr_core usbdr_core_sva chk (
  .REF_CLK(REF_CLK), .RESET_N(RESET_N), .CE(CE), .HOST_MODE(HOST_MODE),
  .SPEED_REQ(SPEED_REQ), .SPEED_OUT(SPEED_OUT), .OTG_REV_SEL(OTG_REV_SEL), .OTG_REV(OTG_REV),
  .SUSPEND(SUSPEND), .SESSION_OFF(SESSION_OFF), .GATE_PHY_CLK(GATE_PHY_CLK),
  .GATE_SYS_CLK(GATE_SYS_CLK), .GATE_RAM_CLK(GATE_RAM_CLK), .PERIODIC_EP(PERIODIC_EP),
  .PKT_REFUSED(PKT_REFUSED), .DMA_REQ(DMA_REQ), .DMA_FIFO(DMA_FIFO), .DMA_ACK(DMA_ACK),
  .ACC_VALID(ACC_VALID), .ACC_WRITE(ACC_WRITE), .ACC_ADDR(ACC_ADDR), .ACC_RDATA(ACC_RDATA),
  .IRQ(IRQ), .ULPI_STP(ULPI_STP));
`default_nettype wire

// ==== test/usbdr_phy_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module usbdr_phy_model (
  output logic            ulpi_clk,
  output logic            ulpi_dir,
  output logic            ulpi_nxt,
  input  wire logic       ulpi_stp,
  input  wire logic [7:0] link_data,
  input  wire logic       link_oe,
  input  wire logic       turn,
  output logic      [7:0] last_byte,
  output logic      [3:0] n_bytes
);
  // Runs free, also while the core sits in reset
  initial begin
    ulpi_clk = 1'b0;
    forever #80 ulpi_clk = ~ulpi_clk;
  end
  initial begin
    ulpi_dir = 1'b0;
    ulpi_nxt = 1'b0;
    last_byte = 8'h00;
    n_bytes = 4'h0;
  end
  always @(posedge ulpi_clk) begin
    if (ulpi_nxt && link_oe && !ulpi_dir) begin
      last_byte <= link_data;
      n_bytes <= n_bytes + 4'h1;
    end
  end
  // Half a period off the edge so the core's synchroniser never races it
  always @(negedge ulpi_clk) begin
    ulpi_dir <= turn;
    ulpi_nxt <= turn || (link_oe && !ulpi_stp && link_data != 8'h00);
  end
endmodule
`default_nettype wire

// ==== test/usbdr_core_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module usbdr_core_tb;
  // Host, speed request, revision, power pair, expected speed, expected gate
  typedef logic [8:0] usbdr_row_type;
  usbdr_row_type rows [6] = '{9'h100, 9'h16B, 9'h195, 9'h039, 9'h042, 9'h0AB};
  logic        ref_clk, reset_n, ce, host_mode, otg_rev_sel, suspend, session_off, size_we;
  logic        pkt_push, pkt_pop, pkt_rx, pkt_per, dma_ack, xfer_ack, xfer_nak, acc_valid;
  logic        acc_write, irq_clr, tx_valid, tx_last, otg_rev, g_phy, g_sys, g_ram, per_over;
  logic        refused, dma_req, sched_valid, ping, irq, u_clk, u_dir, u_nxt, u_oe, u_stp;
  logic        tx_ready, turn, rx_valid;
  logic [1:0]  speed_req, speed_out;
  logic [15:0] active_mask, ep_per, per_ep, acc_addr;
  logic [4:0]  size_idx, dma_fifo;
  logic [9:0]  size_words, threshold, pkt_len;
  logic [3:0]  pkt_ep, sched_idx, n_bytes;
  logic [31:0] acc_wdata, acc_rdata;
  logic [7:0]  u_di, u_do, tx_data, last_byte, rx_data;
  int          n_fail, n_tests, k;
  usbdr_core dut (
    .REF_CLK(ref_clk), .RESET_N(reset_n), .CE(ce), .HOST_MODE(host_mode),
    .SPEED_REQ(speed_req), .SPEED_OUT(speed_out), .OTG_REV_SEL(otg_rev_sel), .OTG_REV(otg_rev),
    .SUSPEND(suspend), .SESSION_OFF(session_off), .GATE_PHY_CLK(g_phy), .GATE_SYS_CLK(g_sys),
    .GATE_RAM_CLK(g_ram), .ACTIVE_MASK(active_mask), .EP_PERIODIC(ep_per), .PERIODIC_EP(per_ep),
    .PERIODIC_OVER(per_over), .SIZE_WE(size_we), .SIZE_IDX(size_idx), .SIZE_WORDS(size_words),
    .THRESHOLD(threshold), .PKT_PUSH(pkt_push), .PKT_POP(pkt_pop), .PKT_RX(pkt_rx),
    .PKT_PERIODIC(pkt_per), .PKT_EP(pkt_ep), .PKT_LEN(pkt_len), .PKT_REFUSED(refused),
    .DMA_REQ(dma_req), .DMA_FIFO(dma_fifo), .DMA_ACK(dma_ack), .SCHED_VALID(sched_valid),
    .SCHED_IDX(sched_idx), .XFER_PING(ping), .XFER_ACK(xfer_ack), .XFER_NAK(xfer_nak),
    .ACC_VALID(acc_valid), .ACC_WRITE(acc_write), .ACC_ADDR(acc_addr), .ACC_WDATA(acc_wdata),
    .ACC_RDATA(acc_rdata), .IRQ(irq), .IRQ_CLR(irq_clr), .ULPI_CLK(u_clk), .ULPI_DIR(u_dir),
    .ULPI_NXT(u_nxt), .ULPI_DATA_I(u_di), .ULPI_DATA_O(u_do), .ULPI_DATA_OE(u_oe),
    .ULPI_STP(u_stp), .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_LAST(tx_last),
    .TX_READY(tx_ready), .RX_VALID(rx_valid), .RX_DATA(rx_data));
  usbdr_phy_model phy (
    .ulpi_clk(u_clk), .ulpi_dir(u_dir), .ulpi_nxt(u_nxt), .ulpi_stp(u_stp),
    .link_data(u_do), .link_oe(u_oe), .turn(turn), .last_byte(last_byte),
    .n_bytes(n_bytes));
  // Turned bus carries a fixed byte; undriven bus shows the inverse
  assign u_di = u_dir ? 8'hC3 : (u_oe ? u_do : ~u_do);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task acc(input logic w, input logic [15:0] a, input logic [31:0] d);
    {acc_valid, acc_write, acc_addr, acc_wdata} = {1'b1, w, a, d};
    @(negedge ref_clk);
    acc_valid = 1'b0;
    @(negedge ref_clk);
  endtask
  task push(input logic [3:0] e, input logic [9:0] l, input logic exp);
    {pkt_push, pkt_ep, pkt_len} = {1'b1, e, l};
    @(negedge ref_clk);
    pkt_push = 1'b0;
    chk("refused", exp, refused);
    @(negedge ref_clk);
  endtask
  task pulse_ack(input logic nak);
    {xfer_nak, xfer_ack} = {nak, !nak};
    @(negedge ref_clk);
    {xfer_nak, xfer_ack} = 2'h0;
    @(negedge ref_clk);
  endtask
  task dma_take(input logic en, input logic [4:0] exp);
    for (k = 0; k < 50 && dma_req !== 1'b1; k++) @(negedge ref_clk);
    if (en) chk("dma fifo", exp, dma_fifo);
    dma_ack = 1'b1;
    @(negedge ref_clk);
    dma_ack = 1'b0;
    if (en) chk("dma drop", 0, dma_req);
  endtask
  task send(input logic [7:0] b, input logic last);
    {tx_valid, tx_data, tx_last} = {1'b1, b, last};
    for (k = 0; k < 400 && tx_ready !== 1'b1; k++) @(negedge ref_clk);
    @(negedge ref_clk);
  endtask
  task do_reset();
    reset_n = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk("stp in reset", 1, u_stp);
    chk("sched idx", 4'hF, sched_idx);
    chk("dma fifo", 5'h10, dma_fifo);
    reset_n = 1'b1;
    for (k = 0; k < 400 && u_stp !== 1'b0; k++) @(negedge ref_clk);
    chk("stp released", 0, u_stp);
  endtask
  task complete_run();
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    $display("watchdog expired");
    complete_run();
  end
  initial begin
    {host_mode, otg_rev_sel, suspend, session_off, size_we, pkt_push, pkt_pop, pkt_rx} = '0;
    {pkt_per, dma_ack, xfer_ack, xfer_nak, acc_valid, acc_write, irq_clr, tx_valid} = '0;
    {tx_last, speed_req, active_mask, ep_per, size_idx, size_words, threshold} = '0;
    {pkt_ep, pkt_len, acc_addr, acc_wdata, tx_data, turn} = '0;
    {ce, n_fail, n_tests} = {1'b1, 32'h0, 32'h0};
    do_reset();
    foreach (rows[i]) begin
      {host_mode, speed_req, otg_rev_sel, suspend, session_off} = rows[i][8:3];
      repeat (2) @(negedge ref_clk);
      chk("speed", rows[i][2:1], speed_out);
      chk("revision", rows[i][5], otg_rev);
      chk("gates", {3{rows[i][0]}}, {g_phy, g_sys, g_ram});
    end
    {ce, session_off} = 2'b00;
    repeat (2) @(negedge ref_clk);
    chk("frozen gate", 1, g_phy);
    ce = 1'b1;
    $display("table done");
    do_reset();
    {host_mode, active_mask, ep_per} = {1'b0, 16'hFFFF, 16'hFFFF};
    repeat (2) @(negedge ref_clk);
    chk("periodic", 16'h007F, per_ep);
    chk("over", 1, per_over);
    for (int g = 0; g < 4; g++) begin
      host_mode = (g != 2);
      acc(1'b1, 16'(g << 12), 32'h1111_1111 * (g + 1));
      acc(1'b0, 16'(g << 12), 32'h0);
      chk("group", 32'h1111_1111 * (g + 1), acc_rdata);
    end
    chk("periodic host", 0, per_ep);
    acc(1'b1, 16'h5000, 32'hA5A5_0001);
    host_mode = 1'b0;
    acc(1'b1, 16'h5000, 32'h5A5A_0002);
    host_mode = 1'b1;
    acc(1'b0, 16'h5000, 32'h0);
    chk("shared", 32'hA5A5_0001, acc_rdata);
    acc(1'b1, 16'h4008, 32'h1234_5678);
    acc(1'b1, 16'h400C, 32'h9ABC_DEF0);
    acc(1'b0, 16'h4008, 32'h0);
    chk("ram", 32'h1234_5678, acc_rdata);
    acc(1'b1, 16'h0004, 32'hDEAD_0004);
    acc(1'b0, 16'h0004, 32'h0);
    chk("unmapped", 0, acc_rdata);
    acc(1'b0, 16'h0000, 32'h0);
    chk("ignored", 32'h1111_1111, acc_rdata);
    acc(1'b0, 16'h7000, 32'h0);
    chk("group seven", 0, acc_rdata);
    chk("irq quiet", 0, irq);
    acc(1'b0, 16'h2000, 32'h0);
    chk("irq host", 1, irq);
    irq_clr = 1'b1;
    @(negedge ref_clk);
    irq_clr = 1'b0;
    @(negedge ref_clk);
    chk("irq cleared", 0, irq);
    $display("registers done");
    host_mode = 1'b0;
    acc(1'b1, 16'h1000, 32'h0);
    chk("irq device", 1, irq);
    {size_we, size_idx, size_words} = {1'b1, 5'h03, 10'h00A};
    @(negedge ref_clk);
    size_we = 1'b0;
    push(4'h3, 10'h008, 1'b0);
    push(4'h3, 10'h008, 1'b1);
    push(4'h4, 10'h008, 1'b0);
    {size_we, size_words} = {1'b1, 10'h020};
    @(negedge ref_clk);
    size_we = 1'b0;
    push(4'h3, 10'h008, 1'b0);
    {pkt_pop, pkt_len} = {1'b1, 10'h008};
    @(negedge ref_clk);
    pkt_pop = 1'b0;
    push(4'h3, 10'h018, 1'b0);
    push(4'h3, 10'h001, 1'b1);
    $display("packets done");
    {host_mode, threshold} = {1'b1, 10'h000};
    dma_take(1'b0, 5'h00);
    dma_take(1'b1, 5'h10);
    threshold = 10'h001;
    dma_take(1'b1, 5'h00);
    dma_take(1'b1, 5'h01);
    pkt_rx = 1'b1;
    push(4'h0, 10'h030, 1'b0);
    push(4'h0, 10'h001, 1'b1);
    {pkt_rx, pkt_per} = 2'b01;
    push(4'h0, 10'h030, 1'b0);
    pkt_per = 1'b0;
    push(4'h0, 10'h030, 1'b0);
    push(4'h0, 10'h001, 1'b1);
    $display("dma done");
    {speed_req, active_mask} = {2'h0, 16'h0001};
    pulse_ack(1'b0);
    chk("sched", 0, sched_idx);
    chk("sched valid", 1, sched_valid);
    pulse_ack(1'b1);
    chk("ping", 1, ping);
    pulse_ack(1'b0);
    chk("ping cleared", 0, ping);
    active_mask = 16'h8000;
    pulse_ack(1'b0);
    chk("sched top", 4'hF, sched_idx);
    $display("scheduler done");
    send(8'h41, 1'b0);
    send(8'h42, 1'b1);
    tx_valid = 1'b0;
    for (k = 0; k < 200 && u_stp !== 1'b1; k++) @(negedge ref_clk);
    chk("stop", 1, u_stp);
    chk("bytes", 2, n_bytes);
    chk("last byte", 8'h42, last_byte);
    for (k = 0; k < 40 && u_stp !== 1'b0; k++) @(negedge ref_clk);
    chk("stop end", 0, u_stp);
    turn = 1'b1;
    for (k = 0; k < 100 && rx_valid !== 1'b1; k++) @(negedge ref_clk);
    chk("rx data", 8'hC3, rx_data);
    chk("oe off", 0, u_oe);
    turn = 1'b0;
    $display("link done");
    complete_run();
  end
endmodule
`default_nettype wire
